// ==== hdl/swb_pkg.sv ====
/*
  Shared constants for the single-wire bus master timing engine:
  slot commands, tick rate and every pulse and slot length in ticks.
  Assumes a 100 MHz system clock and a 1 us time base.
*/
package swb_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam logic [15:0] TICK_DIV_DEFAULT =
    16'(TICK_NS / CLK_PERIOD_NS);

  localparam int CNT_W  = 11;
  localparam int OP_W   = 2;
  localparam int FIFO_DEPTH = 16;

  // Nominal times in microseconds
  localparam int RESET_LOW_US      = 511;
  localparam int RESET_RECOVERY_US = 512;
  localparam int PRESENCE_SAMPLE_US = 70;
  localparam int ZERO_LOW_US       = 100;
  localparam int ONE_LOW_US        = 5;
  localparam int BIT_SLOT_US       = 117;
  localparam int READ_SAMPLE_US    = 13;

  // Same times as tick counts
  localparam logic [CNT_W-1:0] RESET_LOW_TICKS =
    CNT_W'(RESET_LOW_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] RESET_END_TICKS =
    CNT_W'((RESET_LOW_US + RESET_RECOVERY_US) * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] PRESENCE_SAMPLE_TICKS =
    CNT_W'((RESET_LOW_US + PRESENCE_SAMPLE_US) * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] ZERO_LOW_TICKS =
    CNT_W'(ZERO_LOW_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] ONE_LOW_TICKS =
    CNT_W'(ONE_LOW_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] BIT_SLOT_TICKS =
    CNT_W'(BIT_SLOT_US * 1000 / TICK_NS);
  localparam logic [CNT_W-1:0] READ_SAMPLE_TICKS =
    CNT_W'(READ_SAMPLE_US * 1000 / TICK_NS);

  typedef enum logic [OP_W-1:0] {
    OP_RESET  = 2'h0,
    OP_WRITE0 = 2'h1,
    OP_WRITE1 = 2'h2,
    OP_READ   = 2'h3
  } swb_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LOW  = 3'h2,
    ST_HIGH = 3'h4
  } swb_state_e;
endpackage

// ==== hdl/swb_stream_if.sv ====
/*
  Valid/ready word stream between the command FIFO and the slot engine.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface swb_stream_if #(parameter int W = 2);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hdl/swb_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module swb_fifo #(
  parameter int W     = 2,
  parameter int DEPTH = 16
) (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  swb_stream_if.sink   inPort,
  swb_stream_if.source outPort
);
  import swb_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           count;
    logic                    room;
  } swb_fifo_s;

  localparam swb_fifo_s FIFO_RESET =
    '{mem: '0, wp: '0, rp: '0, count: '0, room: 1'b1};

  swb_fifo_s fifo_reg;
  swb_fifo_s fifo_next;
  logic      push;
  logic      pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_comb begin
    fifo_next = fifo_reg;
    // Room is a flop so the upstream ready has no logic in front of it
    push = inPort.valid && fifo_reg.room;
    pop  = (fifo_reg.count != '0) && outPort.ready;
    if (push) begin
      fifo_next.mem[fifo_reg.wp] = inPort.data;
      fifo_next.wp = bump(fifo_reg.wp);
    end
    if (pop) begin
      fifo_next.rp = bump(fifo_reg.rp);
    end
    if (push && !pop) begin
      fifo_next.count = fifo_reg.count + CW'(1);
    end else if (pop && !push) begin
      fifo_next.count = fifo_reg.count - CW'(1);
    end
    fifo_next.room = (fifo_next.count != CW'(DEPTH));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fifo_reg <= FIFO_RESET;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  assign inPort.ready  = fifo_reg.room;
  assign outPort.valid = (fifo_reg.count != '0);
  assign outPort.data  = fifo_reg.mem[fifo_reg.rp];
endmodule // swb_fifo
`default_nettype wire

// ==== hdl/swb_tick.sv ====
/*
  Programmable divider giving a one-cycle time-base tick.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module swb_tick #(
  parameter int DW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [DW-1:0] divisor,
  output logic               tick
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic          tick;
  } swb_tick_s;

  swb_tick_s tick_reg;
  swb_tick_s tick_next;

  always_comb begin
    tick_next = tick_reg;
    tick_next.tick = 1'b0;
    // Divisor 0 behaves as 1: a tick every cycle
    if (tick_reg.cnt + DW'(1) >= divisor) begin
      tick_next.cnt  = '0;
      tick_next.tick = 1'b1;
    end else begin
      tick_next.cnt = tick_reg.cnt + DW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg.tick;
endmodule // swb_tick
`default_nettype wire

// ==== hdl/swb_master.sv ====
/*
  Single-wire bus master timing engine: queued slot commands drive
  reset/presence, write-zero, write-one and read slots on an
  open-drain wire, with results reported one slot at a time.
  Assumes an external pull-up on the wire, a 100 MHz clock and a
  synchronous active-high reset.
*/
// How it works
// - A reset holds the wire low 511 us, then releases it 512 us.
// - A zero bit holds the wire low 100 us before release.
// - A zero-bit slot lasts 117 us from its falling edge.
// - A one bit or read slot holds the wire low 5 us.
// - A one-bit or read slot lasts 117 us from its falling edge.
// - The read bit is sampled at 13 us, before the slave may release.
`timescale 1ns/1ps
`default_nettype none
module swb_master #(
  parameter int DIV_W = 16,
  parameter int DEPTH = swb_pkg::FIFO_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [DIV_W-1:0]         tickDivisor,
  input  wire logic                     cmdValid,
  input  wire logic [swb_pkg::OP_W-1:0] cmdOp,
  output logic                          cmdReady,
  input  wire logic                     wireIn,
  output logic                          wireOut,
  output logic                          wireOe,
  output logic                          rspValid,
  output logic [swb_pkg::OP_W-1:0]      rspOp,
  output logic                          rspBit,
  output logic                          noPresence,
  output logic                          busy
);
  import swb_pkg::*;

  typedef struct packed {
    swb_state_e       state;
    logic [OP_W-1:0]  op;
    logic [CNT_W-1:0] cnt;
    logic             syncA;
    logic             syncB;
    logic             sample;
    logic             oe;
    logic             drv;
    logic             rspValid;
    logic [OP_W-1:0]  rspOp;
    logic             rspBit;
    logic             noPres;
    logic             busy;
  } swb_master_s;

  localparam swb_master_s RESET_STATE = '{
    state: ST_IDLE, op: '0, cnt: '0, syncA: 1'b1, syncB: 1'b1,
    sample: 1'b1, oe: 1'b0, drv: 1'b0, rspValid: 1'b0, rspOp: '0,
    rspBit: 1'b0, noPres: 1'b0, busy: 1'b0};

  swb_master_s m_reg;
  swb_master_s m_next;
  logic        tick;
  logic [CNT_W-1:0] cntInc;

  swb_stream_if #(.W(OP_W)) cmdIn ();
  swb_stream_if #(.W(OP_W)) cmdOut ();

  assign cmdIn.valid = cmdValid;
  assign cmdIn.data  = cmdOp;

  swb_fifo #(
    .W     (OP_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inPort  (cmdIn),
    .outPort (cmdOut)
  );

  swb_tick #(
    .DW (DIV_W)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (tickDivisor),
    .tick    (tick)
  );

  // Ticks the wire stays low for each slot kind
  function automatic logic [CNT_W-1:0] lowTicks(input logic [OP_W-1:0] op);
    case (op)
      OP_RESET:  return RESET_LOW_TICKS;
      OP_WRITE0: return ZERO_LOW_TICKS;
      default:   return ONE_LOW_TICKS;
    endcase
  endfunction

  // Tick at which the wire is sampled
  function automatic logic [CNT_W-1:0] sampleTicks(
    input logic [OP_W-1:0] op);
    // Presence sample lands where every legal slave is low
    if (op == OP_RESET) begin
      return PRESENCE_SAMPLE_TICKS;
    end
    return READ_SAMPLE_TICKS;
  endfunction

  // Tick at which the slot or sequence ends
  function automatic logic [CNT_W-1:0] endTicks(input logic [OP_W-1:0] op);
    if (op == OP_RESET) begin
      return RESET_END_TICKS;
    end
    return BIT_SLOT_TICKS;
  endfunction

  assign cntInc = m_reg.cnt + CNT_W'(1);

  always_comb begin
    m_next = m_reg;
    m_next.rspValid = 1'b0;
    m_next.noPres   = 1'b0;
    m_next.syncA    = wireIn;
    m_next.syncB    = m_reg.syncA;
    cmdOut.ready    = 1'b0;
    case (m_reg.state)
      ST_IDLE: begin
        // Slots start on a tick so every interval is whole ticks
        cmdOut.ready = tick;
        if (tick && cmdOut.valid) begin
          m_next.op    = cmdOut.data;
          m_next.cnt   = '0;
          m_next.oe    = 1'b1;
          m_next.busy  = 1'b1;
          m_next.state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tick) begin
          m_next.cnt = cntInc;
          if (cntInc == lowTicks(m_reg.op)) begin
            m_next.oe    = 1'b0;
            m_next.state = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        if (tick) begin
          m_next.cnt = cntInc;
          if (cntInc == sampleTicks(m_reg.op)) begin
            m_next.sample = m_reg.syncB;
          end
          if (cntInc == endTicks(m_reg.op)) begin
            m_next.state    = ST_IDLE;
            m_next.busy     = 1'b0;
            m_next.rspValid = 1'b1;
            m_next.rspOp    = m_reg.op;
            case (m_reg.op)
              OP_RESET: begin
                m_next.rspBit = !m_reg.sample;
                m_next.noPres = m_reg.sample;
              end
              OP_READ:   m_next.rspBit = m_reg.sample;
              OP_WRITE1: m_next.rspBit = 1'b1;
              default:   m_next.rspBit = 1'b0;
            endcase
          end
        end
      end
      default: begin
        m_next = RESET_STATE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m_reg <= RESET_STATE;
    end else begin
      m_reg <= m_next;
    end
  end

  // Open drain: the driven level is always low
  assign cmdReady   = cmdIn.ready;
  assign wireOut    = m_reg.drv;
  assign wireOe     = m_reg.oe;
  assign rspValid   = m_reg.rspValid;
  assign rspOp      = m_reg.rspOp;
  assign rspBit     = m_reg.rspBit;
  assign noPresence = m_reg.noPres;
  assign busy       = m_reg.busy;
endmodule // swb_master
`default_nettype wire

// ==== verification/swb_master_properties.sv ====
/* Port assertions for the single-wire master.
   Assumes tickDivisor stays fixed while a slot runs. */
`timescale 1ns/1ps
`default_nettype none
module swb_master_properties #(parameter int DIV_W = 16) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic [DIV_W-1:0] tickDivisor,
  input wire logic             cmdValid,
  input wire logic [1:0]       cmdOp,
  input wire logic             cmdReady,
  input wire logic             wireIn,
  input wire logic             wireOut,
  input wire logic             wireOe,
  input wire logic             rspValid,
  input wire logic [1:0]       rspOp,
  input wire logic             rspBit,
  input wire logic             noPresence,
  input wire logic             busy
);
  int   dv, lowCnt, lastLow, spanCnt;
  logic oePrev;
  assign dv = (tickDivisor < 2) ? 1 : int'(tickDivisor);
  // Low time counted in cycles, kept at release for the response check
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oePrev  <= 1'b0;
      lowCnt  <= 0;
      lastLow <= 0;
      spanCnt <= 0;
    end else begin
      oePrev  <= wireOe;
      lowCnt  <= wireOe ? lowCnt + 1 : 0;
      spanCnt <= (wireOe && !oePrev) ? 1 : spanCnt + 1;
      if (oePrev && !wireOe) lastLow <= lowCnt;
    end
  end
  AST_RESET_LOW: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid && rspOp == 2'h0 |-> lastLow == 511 * dv)
    else $error("reset low time wrong");
  AST_RESET_SPAN: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid && rspOp == 2'h0 |->
      spanCnt + 2 >= 1023 * dv && spanCnt <= 1023 * dv + 2)
    else $error("reset recovery wrong");
  AST_ZERO_LOW: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid && rspOp == 2'h1 |-> lastLow == 100 * dv)
    else $error("zero low time wrong");
  AST_ONE_LOW: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid && rspOp[1] |-> lastLow == 5 * dv)
    else $error("one or read low time wrong");
  AST_BIT_SLOT: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid && rspOp != 2'h0 |->
      spanCnt + 2 >= 117 * dv && spanCnt <= 117 * dv + 2)
    else $error("slot length wrong");
  AST_DRIVE_ZERO: assert property (
    @(posedge sys_clk) disable iff (rst)
    wireOe |-> !wireOut && busy)
    else $error("wire driven high or idle");
  AST_NO_PRES: assert property (
    @(posedge sys_clk) disable iff (rst)
    noPresence |-> rspValid && rspOp == 2'h0 && !rspBit)
    else $error("presence event unpaired");
  AST_RSP_PULSE: assert property (
    @(posedge sys_clk) disable iff (rst)
    rspValid |-> !busy ##1 !rspValid)
    else $error("response not a single pulse");
  AST_RST_QUIET: assert property (
    @(posedge sys_clk)
    rst |=> !wireOe && !busy && !rspValid && cmdReady)
    else $error("outputs active in reset");
endmodule // swb_master_properties
bind swb_master swb_master_properties #(.DIV_W(DIV_W)) chk (
  .sys_clk(sys_clk), .rst(rst), .tickDivisor(tickDivisor),
  .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady),
  .wireIn(wireIn), .wireOut(wireOut), .wireOe(wireOe),
  .rspValid(rspValid), .rspOp(rspOp), .rspBit(rspBit),
  .noPresence(noPresence), .busy(busy));
`default_nettype wire

// ==== verification/swb_slave_model.sv ====
/* Behavioural slave on the shared wire.
   Assumes an external pull-up; usNs is one time-base tick in ns. */
`timescale 1ns/1ps
`default_nettype none
module swb_slave_model #(parameter int usNs = 20) (
  input  wire logic lineLvl,
  input  wire logic present,
  input  wire logic nextBit,
  output logic      pullLow
);
  realtime tFall;
  initial pullLow = 1'b0;
  // A zero read bit is held past the sample point, released in window
  always @(negedge lineLvl) begin
    if (!pullLow) begin
      tFall = $realtime;
      if (!nextBit) begin
        pullLow = 1'b1;
        #(30 * usNs) pullLow = 1'b0;
      end
    end
  end
  // Only a long low is a reset; answer after the wait
  always @(posedge lineLvl) begin
    if ($realtime - tFall > 400 * usNs && present) begin
      #(30 * usNs) pullLow = 1'b1;
      // Restart the low timer so our own release is not seen as a reset
      #(120 * usNs) tFall = $realtime;
      pullLow = 1'b0;
    end
  end
endmodule // swb_slave_model
`default_nettype wire

// ==== verification/swb_master_tb_top.sv ====
/* Self-checking bench for the single-wire master.
   Assumes tick divisor 2, so one tick is 20 ns. */
`timescale 1ns/1ps
`default_nettype none
module swb_master_tb_top;
  import swb_pkg::*;
  typedef struct {logic [1:0] op; logic pres, bitIn, expBit, expNp;} swb_row_s;
  swb_row_s rows [6] = '{'{2'h0,1,1,1,0}, '{2'h0,0,1,0,1}, '{2'h1,1,1,0,0},
                         '{2'h2,1,1,1,0}, '{2'h3,1,0,0,0}, '{2'h3,1,1,1,0}};
  logic        sys_clk, rst, cmdValid, cmdReady, wireOut, wireOe, rspValid;
  logic        rspBit, noPresence, busy, present, nextBit, slaveLow, lineLvl;
  logic [1:0]  cmdOp, rspOp;
  logic [15:0] tickDivisor;
  int          n_errors, samples_checked, acc;
  assign lineLvl = !(wireOe || slaveLow);
  swb_master uut (.sys_clk(sys_clk), .rst(rst), .tickDivisor(tickDivisor),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady),
    .wireIn(lineLvl), .wireOut(wireOut), .wireOe(wireOe),
    .rspValid(rspValid), .rspOp(rspOp), .rspBit(rspBit),
    .noPresence(noPresence), .busy(busy));
  swb_slave_model #(.usNs(20)) slave (.lineLvl(lineLvl), .present(present),
    .nextBit(nextBit), .pullLow(slaveLow));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(logic [1:0] op);
    int k;
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdOp = op;
    for (k = 0; k < 3000 && !cmdReady; k++) @(negedge sys_clk);
    if (!cmdReady) begin
      n_errors++;
      wrap_up();
    end
    @(negedge sys_clk);
    cmdValid = 1'b0;
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_rsp();
    int k;
    for (k = 0; k < 3000 && !rspValid; k++) @(posedge sys_clk) #1;
    if (!rspValid) begin
      n_errors++;
      wrap_up();
    end
  endtask
  initial begin
    rst = 1'b1; cmdValid = 1'b0; cmdOp = 2'h0; tickDivisor = 16'h0002;
    present = 1'b1; nextBit = 1'b1; n_errors = 0; samples_checked = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      present = rows[i].pres;
      nextBit = rows[i].bitIn;
      send(rows[i].op);
      wait_rsp();
      check("rspOp", 4'(rspOp), 4'(rows[i].op));
      check("rspBit", 4'(rspBit), 4'(rows[i].expBit));
      check("noPresence", 4'(noPresence), 4'(rows[i].expNp));
      $display("row %0d done", i);
    end
    // Fill the queue until it refuses, then drain it
    nextBit = 1'b1;
    acc = 0;
    for (int k = 0; k < 24; k++) begin
      @(negedge sys_clk);
      cmdOp = 2'h2;
      cmdValid = cmdReady;
      if (cmdReady) acc++;
      if (!cmdReady) break;
    end
    @(negedge sys_clk);
    cmdValid = 1'b0;
    check("refused", 4'(acc >= 16 && !cmdReady), 4'h1);
    repeat (acc) begin
      wait_rsp();
      check("drain op", 4'(rspOp), 4'h2);
      @(posedge sys_clk) #1;
    end
    check("idle", {2'h0, busy, cmdReady}, 4'h1);
    $display("fifo test done");
    // Reset in mid-sequence leaves the wire released
    send(2'h0);
    repeat (40) @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("reset outs", {wireOe, busy, rspValid, cmdReady}, 4'h1);
    rst = 1'b0;
    nextBit = 1'b0;
    send(2'h3);
    wait_rsp();
    check("read after reset", 4'(rspBit), 4'h0);
    $display("reset test done");
    wrap_up();
  end
endmodule // swb_master_tb_top
`default_nettype wire
